/* File: sram_host.v */
// Host controller driving a 1k x 4 asynchronous static memory over its pins
`timescale 1ns/100ps
`include "sram_host_regs.vh"
module sram_host (
   input wire clk,
   input wire rstn,
   input wire reqValid,
   input wire reqWrite,
   input wire [9:0] reqAddr,
   input wire [3:0] reqWdata,
   output wire reqReady,
   output reg [3:0] rspData_r,
   output reg rspValid_r,
   output reg [9:0] word_address,
   output reg chip_select_low_active,
   output reg chip_select_high_active,
   output reg output_disable,
   output reg writeStrobe_n,
   input wire [3:0] shared_data_pins_in,
   output reg [3:0] shared_data_pins_out,
   output reg shared_data_pins_oe_n
);
   // Operation in brief
   //    The memory has no clock, so every phase is a count of our own clock.
   //    One request is taken at a time, only while idle.
   //    A read sets address, selects and enables the outputs in one edge.
   //    Data is sampled only once the full access time has passed.
   //    That covers select-to-valid and enable-to-valid as well.
   //    Sampling late also steps past the old-data hold after an address move.
   //    A write sets address, selects, data and a low strobe in one edge.
   //    The strobe stays low for the write pulse, with data steady throughout.
   //    At the strobe rise the data drive and the selects drop together.
   //    The zero data hold and zero release time make that legal.
   //    Recovery then pads the write out to the full write cycle.
   //    After a read, recovery only waits out the output float time.
   //    The address only moves while the strobe is high.
   //    The outputs stay disabled whenever the host drives the shared pins.
   // Limitations
   //    Figures are for the slowest grade, so faster parts run slower here.
   //    No back-to-back reads without recovery; throughput traded for margin.
   //    Read data is not checked for validity; the pins are sampled as found.
   //    Only this one device is selected; no decode for tied outputs.
   localparam IDLE = 2'd0;
   localparam READ = 2'd1;
   localparam WRITE = 2'd2;
   localparam RECOVER = 2'd3;

   // Least time in ns to whole clock cycles, always rounded up
   function [5:0] cycCeil;
      input integer ns;
      integer c;
      begin
         c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
         cycCeil = c[5:0];
      end
   endfunction

   // Select pin pair {low active, high active} for on or off
   function [1:0] selPins;
      input on;
      begin
         selPins = on ? 2'b01 : 2'b10;
      end
   endfunction

   // Phase lengths in cycles of our own clock
   localparam [5:0] READ_CNT = cycCeil(`READ_CYCLE_MIN_NS);
   localparam [5:0] WPULSE_CNT = cycCeil(`WRITE_PULSE_MIN_NS);
   localparam [5:0] WCYCLE_CNT = cycCeil(`WRITE_CYCLE_MIN_NS);
   localparam [5:0] FLOAT_CNT = cycCeil(`FLOAT_AFTER_DISABLE_MAX_NS);

   // Remembers which kind of cycle recovery must close
   reg lastWrite_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [5:0] count_r;
   reg [5:0] count_nxt;

   // Requests are taken only in idle, so address never moves mid-cycle
   assign reqReady = (state_r == IDLE);

   // Next state and cycle count
   always @* begin
      state_nxt = state_r;
      count_nxt = count_r;
      case (state_r)
         IDLE: begin
            if (reqValid) begin
               state_nxt = reqWrite ? WRITE : READ;
               count_nxt = 6'h01;
            end
         end
         READ: begin
            count_nxt = count_r + 6'h01;
            if (count_r == READ_CNT) begin
               state_nxt = RECOVER;
               count_nxt = 6'h01;
            end
         end
         WRITE: begin
            count_nxt = count_r + 6'h01;
            if (count_r == WPULSE_CNT) begin
               state_nxt = RECOVER;
               count_nxt = WPULSE_CNT + 6'h01;
            end
         end
         RECOVER: begin
            // Read waits out float time; write pads to the full write cycle
            count_nxt = count_r + 6'h01;
            if (count_r >= (lastWrite_r ? WCYCLE_CNT : FLOAT_CNT)) begin
               state_nxt = IDLE;
               count_nxt = 6'h00;
            end
         end
         default: begin
            state_nxt = IDLE;
            count_nxt = 6'h00;
         end
      endcase
   end

   // State, pins and response registers
   always @(posedge clk) begin
      if (!rstn) begin
         state_r <= IDLE;
         count_r <= 6'h00;
         lastWrite_r <= 1'b0;
         rspData_r <= 4'h0;
         rspValid_r <= 1'b0;
         word_address <= 10'h000;
         chip_select_low_active <= 1'b1;
         chip_select_high_active <= 1'b0;
         output_disable <= 1'b1;
         writeStrobe_n <= 1'b1;
         shared_data_pins_out <= 4'h0;
         shared_data_pins_oe_n <= 1'b1;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         rspValid_r <= 1'b0;
         case (state_r)
            IDLE: begin
               if (reqValid) begin
                  // Strobe still high as the address moves
                  word_address <= reqAddr;
                  lastWrite_r <= reqWrite;
                  {chip_select_low_active, chip_select_high_active} <= selPins(1'b1);
                  output_disable <= reqWrite;
                  writeStrobe_n <= ~reqWrite;
                  shared_data_pins_out <= reqWdata;
                  shared_data_pins_oe_n <= ~reqWrite;
               end
            end
            READ: begin
               if (count_r == READ_CNT) begin
                  // Sampled after full access time, no inversion; old data long gone
                  rspData_r <= shared_data_pins_in;
                  rspValid_r <= 1'b1;
                  output_disable <= 1'b1;
                  {chip_select_low_active, chip_select_high_active} <= selPins(1'b0);
               end
            end
            WRITE: begin
               if (count_r == WPULSE_CNT) begin
                  // Data dropped with strobe rise; zero hold is allowed
                  writeStrobe_n <= 1'b1;
                  shared_data_pins_oe_n <= 1'b1;
                  {chip_select_low_active, chip_select_high_active} <= selPins(1'b0);
               end
            end
            default: begin
            end
         endcase
      end
   end
endmodule // sram_host

/* File: sram_host_regs.vh */
// Pin timing constants for the host that drives the 1k x 4 static memory
`ifndef SRAM_HOST_REGS_VH
`define SRAM_HOST_REGS_VH
`define CLK_PERIOD_NS 25
`define ADDR_W 10
`define DATA_W 4
`define WORDS 1024
// Slowest grade figures, in ns, so any fitted grade is served
`define READ_CYCLE_MIN_NS 450
`define ACCESS_MAX_NS 450
`define WRITE_CYCLE_MIN_NS 450
`define WRITE_PULSE_MIN_NS 200
`define DATA_OVERLAP_MIN_NS 200
`define FLOAT_AFTER_DISABLE_MAX_NS 100
`define WRITE_RELEASE_MIN_NS 0
`define DATA_HOLD_MIN_NS 0
// Cycle counts, least times rounded up
`define READ_CYCLES ((`READ_CYCLE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYCLES ((`WRITE_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYCLE_CYCLES ((`WRITE_CYCLE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLOAT_CYCLES ((`FLOAT_AFTER_DISABLE_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: sram_mem_model.sv */
// Behavioural 1k x 4 static memory at the far side of the host
`timescale 1ns/100ps
module sram_mem_model (
   input [9:0] word_address,
   input chip_select_low_active,
   input chip_select_high_active,
   input output_disable,
   input writeStrobe_n,
   input [3:0] shared_data_pins_in,
   output [3:0] memOut,
   output memDrv);
   reg [3:0] mem [0:1023];
   wire sel = !chip_select_low_active && chip_select_high_active;
   wire wrOpen = sel && !writeStrobe_n;
   assign memDrv = sel && writeStrobe_n && !output_disable;
   assign memOut = mem[word_address];
   // No clock; latch at end of overlap, as data hold is zero
   always @(negedge wrOpen) mem[word_address] = shared_data_pins_in;
endmodule // sram_mem_model

/* File: sram_host_chk.sv */
// Pin protocol checker for the memory host
`timescale 1ns/100ps
module sram_host_chk (
   input clk,
   input rstn,
   input [9:0] word_address,
   input chip_select_low_active,
   input chip_select_high_active,
   input output_disable,
   input writeStrobe_n,
   input shared_data_pins_oe_n);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_SEL: assert property (chip_select_low_active != chip_select_high_active) else $error("sel");
   AST_ADR: assert property (!writeStrobe_n [*2] |-> $stable(word_address)) else $error("adr");
   AST_WPL: assert property ($fell(writeStrobe_n) |-> !writeStrobe_n [*8]) else $error("wpl");
   AST_DAT: assert property (shared_data_pins_oe_n == writeStrobe_n) else $error("dat");
   AST_RLN: assert property ($rose(output_disable) |-> !$past(output_disable, 18)) else $error("rln");
   AST_RAD: assert property (!output_disable [*2] |-> $stable(word_address)) else $error("rad");
endmodule // sram_host_chk
bind sram_host sram_host_chk u_chk (.*);

/* File: sram_host_test.sv */
// Bench for the memory host
`timescale 1ns/100ps
`include "sram_host_regs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("MISMATCH %0t", $time); end end
module sram_host_test;
   reg clk = 0, rstn = 0, reqValid = 0, reqWrite = 0;
   reg [9:0] reqAddr = 0;
   reg [3:0] reqWdata = 0;
   int n_fail, checks;
   wire reqReady, rspValid_r, chip_select_low_active, chip_select_high_active, output_disable, writeStrobe_n;
   wire shared_data_pins_oe_n, memDrv;
   wire [3:0] rspData_r, shared_data_pins_out, memOut;
   wire [9:0] word_address;
   // Released pins show inverted data, no pull
   wire [3:0] #1 shared_data_pins_in = memDrv ? memOut : shared_data_pins_oe_n ? ~memOut : shared_data_pins_out;
   sram_host u_sram_host (.*);
   sram_mem_model u_sram_mem_model (.*);
   initial forever #12.5 clk = ~clk;
   // Hang guard
   initial begin
      repeat (600) @(posedge clk);
      n_fail++;
      end_of_test;
   end
   task req(input w, input [9:0] a, input [3:0] d);
      // Raise only when idle, hold one edge for the take, then drop
      while (!reqReady) @(posedge clk);
      {reqValid, reqWrite, reqAddr, reqWdata} <= {1'h1, w, a, d};
      @(posedge clk);
      reqValid <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input [9:0] a, input [3:0] e);
      req(1'h0, a, 4'h0);
      // Pulse is set at the edge where the count ends, seen at the next one
      repeat (`READ_CYCLES) @(posedge clk);
      `CHK({rspValid_r, rspData_r}, {1'h1, e})
   endtask
   task t_edges;
      req(1, 10'h0, 4'hA);
      req(1, 10'h3FF, 4'h5);
      rd(10'h3FF, 4'h5);
      rd(10'h0, 4'hA);
   endtask
   task end_of_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1;
      t_edges;
      end_of_test;
   end
endmodule // sram_host_test
